//--- ptfim_pkg.sv
package ptfim_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] PTFIM_ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] PTFIM_ADDR_TRIM = 8'h1B;
  localparam logic [7:0] PTFIM_ADDR_HOLDOFF = 8'h1C;
  localparam logic [7:0] PTFIM_ADDR_MAP = 8'h20;
  localparam logic [7:0] PTFIM_ADDR_TRIM_INFO = 8'h27;

  // ==========================================================================
  // Trim register field positions.
  localparam int PTFIM_TRIM_DONE_BIT = 6;
  localparam int PTFIM_TRIM_FIELD_BIT = 1;
  localparam int PTFIM_TRIM_CMD_BIT = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] PTFIM_MAP_RESET = 32'h0001_2345;
  localparam logic [7:0] PTFIM_HOLDOFF_RESET = 8'h00;
  localparam logic [7:0] PTFIM_CLK_CTRL_RESET = 8'h00;

  // ==========================================================================
  // Hold-off timing: one step is 1.3 ms, codes at or above ten saturate.
  localparam int PTFIM_CLK_HZ = 100_000_000;
  localparam int PTFIM_STEP_US = 1300;
  localparam int PTFIM_STEP_CYCLES = (PTFIM_CLK_HZ / 1_000_000) * PTFIM_STEP_US;
  localparam logic [3:0] PTFIM_HOLDOFF_MAX_CODE = 4'hA;
  localparam int PTFIM_MIN_HOLD_CYCLES = 1;

  // ==========================================================================
  // Serial input half-channel selection codes and channel count.
  localparam int PTFIM_NUM_CH = 6;
  localparam logic [3:0] PTFIM_SRC_MAX = 4'h5;

  // Register bus request carried into the block.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ptfim_req_t;

  // Recovery sequencer states.
  typedef enum logic [1:0] {
    PTFIM_RUN = 2'b00,
    PTFIM_HOLD = 2'b01
  } ptfim_state_t;

endpackage : ptfim_pkg

//--- ptfim_input_map.sv
// Input selector: every internal channel picks any left or right half.
module ptfim_input_map
  import ptfim_pkg::*;
(
  input wire logic [31:0] map_cfg,
  input wire logic [5:0] half_samples,
  output logic [PTFIM_NUM_CH-1:0] ch_samples
);

  // ==========================================================================
  // Selection decode used by every channel.
  function automatic logic pick(input logic [3:0] code, input logic [5:0] src);
    // Out-of-range codes select silence.
    pick = (code <= PTFIM_SRC_MAX) ? src[code[2:0]] : 1'b0;
  endfunction : pick

  // ==========================================================================
  // Channel one sits in the highest used nibble, channel six in the lowest.
  for (genvar g = 0; g < PTFIM_NUM_CH; g++)
  begin : g_ch
    // Independent selectors allow the same source on many channels.
    assign ch_samples[g] = pick(map_cfg[4*(PTFIM_NUM_CH-1-g) +: 4], half_samples);
  end

endmodule : ptfim_input_map

//--- ptfim_regs.sv
module ptfim_regs
  import ptfim_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ptfim_req_t req,
  output logic [31:0] rdata_q,
  output logic rvalid_q,
  input wire logic [7:0] trim_info,
  input wire logic trim_complete,
  output logic trim_start_q,
  output logic trim_field_q,
  input wire logic backend_error,
  input wire logic [5:0] pwm_in,
  output logic [5:0] pwm_out_q,
  input wire logic group_one_in,
  input wire logic group_two_in,
  output logic shutdown_group_one_enable_q,
  output logic shutdown_group_two_enable_q,
  input wire logic [1:0] serial_audio_in_first,
  input wire logic [1:0] serial_audio_in_second,
  input wire logic [1:0] serial_audio_in_third,
  output logic [PTFIM_NUM_CH-1:0] channel_data_q,
  output logic [7:0] clk_ctrl_q
);

  // ==========================================================================
  // Register state.
  logic [7:0] clk_ctrl_d;
  logic trim_field_d;
  logic trim_start_d;
  logic trim_done_q; // Sticky completion flag.
  logic trim_done_d;
  logic [7:0] holdoff_q; // Hold-off code register.
  logic [7:0] holdoff_d;
  logic [31:0] map_q; // Input map register.
  logic [31:0] map_d;
  logic [31:0] rdata_d;
  logic rvalid_d;

  // Register writes, reads and the trim command.
  always_comb
  begin
    clk_ctrl_d = clk_ctrl_q;
    trim_field_d = trim_field_q;
    trim_start_d = 1'b0;
    trim_done_d = trim_done_q | trim_complete;
    holdoff_d = holdoff_q;
    map_d = map_q;
    rdata_d = 32'h0000_0000;
    rvalid_d = req.rd;
    if (req.wr)
    begin
      unique case (req.addr)
        PTFIM_ADDR_CLK_CTRL: clk_ctrl_d = req.wdata[7:0];
        PTFIM_ADDR_TRIM:
        begin
          // Field select is stored; a one in the command bit issues a pulse.
          trim_field_d = req.wdata[PTFIM_TRIM_FIELD_BIT];
          trim_start_d = req.wdata[PTFIM_TRIM_CMD_BIT];
          // A new command clears done unless completion arrives together.
          if (req.wdata[PTFIM_TRIM_CMD_BIT] && !trim_complete)
          begin
            trim_done_d = 1'b0;
          end
        end
        PTFIM_ADDR_HOLDOFF: holdoff_d = {4'h0, req.wdata[3:0]};
        PTFIM_ADDR_MAP: map_d = {8'h00, req.wdata[23:0]};
        default:
        begin
          // Unmapped writes are ignored.
        end
      endcase
    end
    if (req.rd)
    begin
      unique case (req.addr)
        PTFIM_ADDR_CLK_CTRL: rdata_d = {24'h0, clk_ctrl_q};
        PTFIM_ADDR_TRIM: rdata_d = {25'h0, trim_done_q, 4'h0, trim_field_q, 1'b0};
        PTFIM_ADDR_HOLDOFF: rdata_d = {24'h0, holdoff_q};
        PTFIM_ADDR_MAP: rdata_d = map_q;
        PTFIM_ADDR_TRIM_INFO: rdata_d = {24'h0, trim_info};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_ctrl_q <= PTFIM_CLK_CTRL_RESET;
      trim_field_q <= 1'b0;
      trim_start_q <= 1'b0;
      trim_done_q <= 1'b0;
      holdoff_q <= PTFIM_HOLDOFF_RESET;
      map_q <= PTFIM_MAP_RESET;
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      clk_ctrl_q <= clk_ctrl_d;
      trim_field_q <= trim_field_d;
      trim_start_q <= trim_start_d;
      trim_done_q <= trim_done_d;
      holdoff_q <= holdoff_d;
      map_q <= map_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================================
  // Back-end error recovery.
  ptfim_state_t state_q; // Recovery state.
  ptfim_state_t state_d;
  logic [31:0] hold_cnt_q; // Remaining hold-off cycles.
  logic [31:0] hold_cnt_d;
  logic [5:0] pwm_out_d;
  logic grp1_d;
  logic grp2_d;

  // Hold-off length in cycles for a code; saturates at ten steps.
  function automatic logic [31:0] hold_cycles(input logic [3:0] code);
    logic [3:0] steps;
    steps = (code >= PTFIM_HOLDOFF_MAX_CODE) ? PTFIM_HOLDOFF_MAX_CODE : code;
    hold_cycles = (steps == 4'h0) ? 32'(PTFIM_MIN_HOLD_CYCLES) : 32'(steps) * 32'(PTFIM_STEP_CYCLES);
  endfunction : hold_cycles

  // Sequencer: an error forces everything low, then counts out the hold-off.
  always_comb
  begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    pwm_out_d = pwm_in;
    grp1_d = group_one_in;
    grp2_d = group_two_in;
    unique case (state_q)
      PTFIM_RUN:
      begin
        if (backend_error)
        begin
          state_d = PTFIM_HOLD;
          hold_cnt_d = hold_cycles(holdoff_q[3:0]);
        end
      end
      PTFIM_HOLD:
      begin
        if (backend_error)
        begin
          // A persisting error restarts the wait.
          hold_cnt_d = hold_cycles(holdoff_q[3:0]);
        end
        else if (hold_cnt_q <= 32'd1)
        begin
          state_d = PTFIM_RUN;
        end
        else
        begin
          hold_cnt_d = hold_cnt_q - 32'd1;
        end
      end
    endcase
    if (backend_error || state_d == PTFIM_HOLD)
    begin
      pwm_out_d = 6'h00;
      grp1_d = 1'b0;
      grp2_d = 1'b0;
    end
  end

  // Recovery registers; outputs leave reset low.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= PTFIM_RUN;
      hold_cnt_q <= 32'h0000_0000;
      pwm_out_q <= 6'h00;
      shutdown_group_one_enable_q <= 1'b0;
      shutdown_group_two_enable_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      pwm_out_q <= pwm_out_d;
      shutdown_group_one_enable_q <= grp1_d;
      shutdown_group_two_enable_q <= grp2_d;
    end
  end

  // ==========================================================================
  // Input_channel_map.
  logic [PTFIM_NUM_CH-1:0] ch_d;

  ptfim_input_map u_map (
    .map_cfg(map_q),
    .half_samples({serial_audio_in_third, serial_audio_in_second, serial_audio_in_first}),
    .ch_samples(ch_d)
  );

  // Registered channel outputs.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      channel_data_q <= '0;
    end
    else
    begin
      channel_data_q <= ch_d;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_error_seen;
    backend_error;
  endsequence

  a_error_forces_low: assert property (@(posedge mclk) disable iff (sys_rst)
    s_error_seen |=> (pwm_out_q == 6'h00 && !shutdown_group_one_enable_q && !shutdown_group_two_enable_q))
    else $error("outputs not forced low after back-end error");

  a_hold_enters: assert property (@(posedge mclk) disable iff (sys_rst)
    s_error_seen |=> state_q == PTFIM_HOLD)
    else $error("hold-off not entered on error");

  a_hold_keeps_low: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == PTFIM_HOLD && hold_cnt_q > 32'd1 && !backend_error) |=> state_q == PTFIM_HOLD)
    else $error("hold-off ended early");

  // Trim command write on the bus this cycle; back-to-back commands may follow each other.
  logic trim_cmd;
  assign trim_cmd = req.wr && (req.addr == PTFIM_ADDR_TRIM) && req.wdata[PTFIM_TRIM_CMD_BIT];

  a_trim_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    trim_cmd |=> trim_start_q ##1 (!trim_start_q || $past(trim_cmd)))
    else $error("trim command pulse wrong");

  a_done_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    trim_complete |=> trim_done_q)
    else $error("trim done flag not set");

  a_info_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (req.rd && req.addr == PTFIM_ADDR_TRIM_INFO) |=> rdata_q == {24'h0, $past(trim_info)})
    else $error("trim info read wrong");

  a_map_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
    map_q[31:24] == 8'h00)
    else $error("map reserved bits nonzero");

  a_map_route: assert property (@(posedge mclk) disable iff (sys_rst)
    (map_q[23:20] == 4'h0) |=> channel_data_q[0] == $past(serial_audio_in_first[0]))
    else $error("channel one routing wrong");

endmodule : ptfim_regs

//--- ptfim_host.sv
// ==========
// Host model: drives register requests on the falling edge.
module ptfim_host
  import ptfim_pkg::*;
(
  input wire logic mclk,
  output ptfim_req_t req,
  input wire logic [31:0] rdata_q,
  input wire logic rvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // One write strobe, held for one cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    req = '0;
  endtask : wr
  // One read; the answer is taken in its single valid cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d = 'x;
    @(negedge mclk);
    req = '{1'b0, 1'b1, a, 32'h0};
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(negedge mclk);
      req = '0;
      if (rvalid_q === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_q;
      end
    end
  endtask : rd
  // Unknown-rate trim, run once after a reset.
  task automatic trim_unknown(output bit ok);
    logic [31:0] v;
    ok = 1'b0;
    wr(8'h00, 32'h6D);
    wr(8'h1B, 32'h01);
    for (int n = 0; n < 8 && !ok; n++)
    begin
      rd(8'h27, v, ok);
      ok = ok && v[3:2] != 2'h0 && v[1:0] != 2'h0;
    end
    if (ok)
    begin
      wr(8'hF8, 32'hA5A5A5A5);
      wr(8'hC9, 32'h000600EF);
      wr(8'hCA, 32'h0);
      wr(8'hCA, {30'h0, v[5:4]});
      wr(8'hC9, 32'h000600F1);
      wr(8'hCA, 32'h0);
      wr(8'hCA, {30'h0, v[7:6]});
    end
  endtask : trim_unknown
endmodule : ptfim_host

//--- pwm_proc_trim_fault_input_map_regs_tb.sv
// ==========
// Bench for the register block.
module pwm_proc_trim_fault_input_map_regs_tb;
  import ptfim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] wv;
    logic [31:0] rv;
    logic [5:0] sv;
    logic [5:0] cv;
  } ptfim_row_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] trim_info = 8'h9E;
  logic trim_complete = 1'b0;
  logic backend_error = 1'b0;
  logic [5:0] pwm_in = 6'h2A;
  logic [5:0] sdin = 6'h00;
  ptfim_req_t req;
  logic [31:0] rdata_q;
  logic rvalid_q, trim_start_q, trim_field_q, g1_q, g2_q;
  logic [5:0] pwm_out_q, channel_data_q;
  logic [7:0] clk_ctrl_q;
  int failures = 0;
  int tests_run = 0;
  // Map written, map read back, serial halves, expected channels.
  ptfim_row_t rows [4] = '{'{32'h00012345, 32'h00012345, 6'h26, 6'h26},
    '{32'h00555555, 32'h00555555, 6'h20, 6'h3F}, '{32'h00543210, 32'h00543210, 6'h03, 6'h30},
    '{32'hFF0000F6, 32'h000000F6, 6'h01, 6'h0F}};
  always #5 mclk = ~mclk;
  ptfim_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .trim_info(trim_info), .trim_complete(trim_complete), .trim_start_q(trim_start_q),
    .trim_field_q(trim_field_q), .backend_error(backend_error), .pwm_in(pwm_in), .pwm_out_q(pwm_out_q),
    .group_one_in(1'b1), .group_two_in(1'b1), .shutdown_group_one_enable_q(g1_q),
    .shutdown_group_two_enable_q(g2_q), .serial_audio_in_first(sdin[1:0]),
    .serial_audio_in_second(sdin[3:2]), .serial_audio_in_third(sdin[5:4]),
    .channel_data_q(channel_data_q), .clk_ctrl_q(clk_ctrl_q));
  ptfim_host host_u (.mclk(mclk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
  // ==========
  // Shared tasks.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bit ok;
    host_u.rd(a, d, ok);
    chk(d, e);
  endtask : rc
  // Reads the trim register; compares done flag and field select.
  task automatic rt(input logic [1:0] e);
    logic [31:0] d;
    bit ok;
    host_u.rd(PTFIM_ADDR_TRIM, d, ok);
    chk({d[6], d[1]}, e);
  endtask : rt
  task automatic rst();
    sys_rst = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
  endtask : rst
  task automatic conclude();
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // ==========
  // Main sequence.
  initial
  begin
    bit ok;
    int n;
    rst();
    rc(PTFIM_ADDR_MAP, 32'h00012345);
    rc(PTFIM_ADDR_HOLDOFF, 32'h0);
    rc(8'h30, 32'h0);
    rt(2'b00);
    foreach (rows[i])
    begin
      host_u.wr(PTFIM_ADDR_MAP, rows[i].wv);
      rc(PTFIM_ADDR_MAP, rows[i].rv);
      sdin = rows[i].sv;
      repeat (2) @(negedge mclk);
      chk(32'(channel_data_q), 32'(rows[i].cv));
    end
    host_u.wr(PTFIM_ADDR_CLK_CTRL, 32'h6D);
    host_u.wr(PTFIM_ADDR_TRIM, 32'h03);
    chk({trim_start_q, trim_field_q}, 2'b11);
    @(negedge mclk);
    chk(trim_start_q, 1'b0);
    chk(clk_ctrl_q, 8'h6D);
    rt(2'b01);
    trim_complete = 1'b1;
    @(negedge mclk);
    trim_complete = 1'b0;
    rt(2'b11);
    host_u.wr(PTFIM_ADDR_TRIM, 32'h40);
    rt(2'b10);
    rc(PTFIM_ADDR_TRIM_INFO, 32'h9E);
    host_u.wr(PTFIM_ADDR_TRIM_INFO, 32'h0);
    rc(PTFIM_ADDR_TRIM_INFO, 32'h9E);
    // Second reset, then the other trim flow through unmapped places.
    rst();
    host_u.trim_unknown(ok);
    chk(ok, 1'b1);
    chk(clk_ctrl_q, 8'h6D);
    rt(2'b00);
    rc(PTFIM_ADDR_MAP, 32'h00012345);
    host_u.wr(PTFIM_ADDR_HOLDOFF, 32'hFF);
    rc(PTFIM_ADDR_HOLDOFF, 32'h0F);
    host_u.wr(PTFIM_ADDR_HOLDOFF, 32'h0);
    chk({g2_q, g1_q, pwm_out_q}, 8'hEA);
    backend_error = 1'b1;
    @(negedge mclk);
    chk({g2_q, g1_q, pwm_out_q}, 8'h00);
    repeat (3) @(negedge mclk);
    backend_error = 1'b0;
    chk({g2_q, g1_q, pwm_out_q}, 8'h00);
    for (n = 0; n < 6 && pwm_out_q !== 6'h2A; n++)
      @(negedge mclk);
    if (n == 6)
    begin
      failures++;
      conclude();
    end
    chk({g2_q, g1_q, pwm_out_q}, 8'hEA);
    host_u.wr(PTFIM_ADDR_HOLDOFF, 32'h01);
    backend_error = 1'b1;
    @(negedge mclk);
    backend_error = 1'b0;
    repeat (200) @(negedge mclk);
    chk({g2_q, g1_q, pwm_out_q}, 8'h00);
    conclude();
  end
endmodule : pwm_proc_trim_fault_input_map_regs_tb
